// file: rtl/prs_defines.svh
/*
  Constants of the pattern register access block: field positions,
  power-up patterns, burst codes and counts.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef PRS_DEFINES_SVH
`define PRS_DEFINES_SVH

// ************************************
// mode register fields
// ************************************
`define PRS_MR_W 13
`define PRS_MR_NUM 7
`define PRS_MR_BURST 0
`define PRS_MR_PARITY 5
`define PRS_MR_CTRL 3
`define PRS_MR3_EN_BIT 2
`define PRS_MR3_PAGE_LSB 0
`define PRS_MR3_FMT_LSB 11
`define PRS_BL8_CODE 3'h0
`define PRS_BC4_CODE 3'h4

// ************************************
// pattern storage
// ************************************
`define PRS_LOC0_INIT 8'h55
`define PRS_LOC1_INIT 8'h33
`define PRS_LOC2_INIT 8'h0F
`define PRS_LOC3_INIT 8'h00
`define PRS_LOCS 4
`define PRS_LANES 8
`define PRS_BL8_LAST 3'h7
`define PRS_BC4_LAST 3'h3

`endif

// file: rtl/prs_pkg.sv
/*
  Types of the pattern register access block.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package prs_pkg;
  typedef enum logic [2:0] {
    PRS_CMD_DES, PRS_CMD_MRS, PRS_CMD_RD, PRS_CMD_RDA,
    PRS_CMD_WR, PRS_CMD_WRA, PRS_CMD_REF, PRS_CMD_OTHER
  } prs_cmd_t;
  typedef enum logic [1:0] {
    PRS_FMT_SERIAL, PRS_FMT_PARALLEL, PRS_FMT_STAGGER, PRS_FMT_RSVD
  } prs_fmt_t;
  typedef enum logic {PRS_ST_IDLE, PRS_ST_BURST} prs_state_t;
endpackage

`default_nettype wire

// file: rtl/prs_sync.sv
/*
  Two flip-flop level synchroniser.
  Assumes each bit is a level or toggle that is stable for several
  destination clocks, and a reset of the destination domain.
*/
`default_nettype none

module prs_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
    end else begin
      meta_q <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= meta_q;
    end
  end
endmodule

`default_nettype wire

// file: rtl/prs_pattern_mem.sv
/*
  Writable page 0 pattern storage: four 8-bit locations with
  power-up patterns, all four read out through a register.
  Assumes the link clock and the link-domain reset.
*/
`include "prs_defines.svh"
`default_nettype none

module prs_pattern_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic init,
  input wire logic wr_en,
  input wire logic [1:0] wr_loc,
  input wire logic [7:0] wr_data,
  output logic [31:0] rd_bytes
);
  localparam logic [31:0] INIT = {`PRS_LOC3_INIT, `PRS_LOC2_INIT,
                                  `PRS_LOC1_INIT, `PRS_LOC0_INIT};
  logic [7:0] loc_q [`PRS_LOCS];

  genvar i;
  generate
    for (i = 0; i < `PRS_LOCS; i++) begin : g_loc
      always_ff @(posedge clk) begin
        if (rst || init) begin
          loc_q[i] <= INIT[8*i +: 8];
        end else if (wr_en && wr_loc == 2'(i)) begin
          loc_q[i] <= wr_data;
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          rd_bytes[8*i +: 8] <= INIT[8*i +: 8];
        end else begin
          rd_bytes[8*i +: 8] <= loc_q[i];
        end
      end
    end
  endgenerate
endmodule

`default_nettype wire

// file: rtl/prs_top.sv
/*
  Pattern register access mode of a DRAM device: mode register image,
  command steering, page 0 pattern storage, parity error frame page,
  mode register readback page and serial, parallel and staggered burst
  readout on eight data lanes.
  Assumes commands arrive on dram_ck, one per cycle with cmd_valid,
  and the core side on core_clk; the two clocks are unrelated.
*/
`include "prs_defines.svh"
`default_nettype none

module prs_top (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic err_frame_valid,
  input wire logic [31:0] err_frame,
  output logic err_frame_busy,
  input wire logic reinit,
  output logic pattern_mode_active,
  input wire logic dram_ck,
  input wire logic cmd_valid,
  input wire prs_pkg::prs_cmd_t cmd_code,
  input wire logic cmd_bg,
  input wire logic [1:0] cmd_ba,
  input wire logic [`PRS_MR_W-1:0] cmd_addr,
  output logic [`PRS_LANES-1:0] dq_o,
  output logic dq_oe_n,
  output logic dq_beat_valid,
  output logic arr_cmd_valid,
  output prs_pkg::prs_cmd_t arr_cmd_code,
  output logic arr_auto_pre
);
  // ************************************
  // core domain
  // ************************************
  logic [31:0] frame_q;
  logic req_tgl_q;
  logic re_tgl_q;
  logic ack_sync;
  logic act_sync;

  assign err_frame_busy = req_tgl_q != ack_sync;

  // frame held stable until the link side acknowledges it
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      frame_q <= 32'h0000_0000;
      req_tgl_q <= 1'b0;
    end else if (err_frame_valid && !err_frame_busy) begin
      frame_q <= err_frame;
      req_tgl_q <= ~req_tgl_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      re_tgl_q <= 1'b0;
    end else if (reinit) begin
      re_tgl_q <= ~re_tgl_q;
    end
  end

  assign pattern_mode_active = act_sync;

  // ************************************
  // crossings
  // ************************************
  logic lnk_rst;
  logic [1:0] lnk_tgl;
  logic ack_tgl_q;
  logic mpr_on;

  prs_sync #(.W(1)) u_rst_sync (
    .clk(dram_ck),
    .rst(1'b0),
    .d(sys_rst),
    .q(lnk_rst)
  );

  prs_sync #(.W(2)) u_to_link (
    .clk(dram_ck),
    .rst(lnk_rst),
    .d({req_tgl_q, re_tgl_q}),
    .q(lnk_tgl)
  );

  prs_sync #(.W(2)) u_to_core (
    .clk(core_clk),
    .rst(sys_rst),
    .d({ack_tgl_q, mpr_on}),
    .q({ack_sync, act_sync})
  );

  // ************************************
  // link events
  // ************************************
  logic re_seen_q;
  logic req_evt;
  logic reinit_evt;
  logic parity_en;
  logic [31:0] err_page_q;

  assign req_evt = lnk_tgl[1] != ack_tgl_q;
  assign reinit_evt = lnk_tgl[0] != re_seen_q;

  always_ff @(posedge dram_ck) begin
    if (lnk_rst) begin
      re_seen_q <= 1'b0;
    end else begin
      re_seen_q <= lnk_tgl[0];
    end
  end

  always_ff @(posedge dram_ck) begin
    if (lnk_rst) begin
      ack_tgl_q <= 1'b0;
    end else if (req_evt) begin
      ack_tgl_q <= lnk_tgl[1];
    end
  end

  always_ff @(posedge dram_ck) begin
    if (lnk_rst || reinit_evt) begin
      err_page_q <= 32'h0000_0000;
    end else if (req_evt && parity_en) begin
      err_page_q <= frame_q;
    end
  end

  // ************************************
  // mode register image
  // ************************************
  logic [`PRS_MR_W-1:0] mr_q [`PRS_MR_NUM];
  logic is_mrs;

  assign is_mrs = cmd_valid && cmd_code == prs_pkg::PRS_CMD_MRS;

  genvar m;
  generate
    for (m = 0; m < `PRS_MR_NUM; m++) begin : g_mr
      always_ff @(posedge dram_ck) begin
        if (lnk_rst || reinit_evt) begin
          mr_q[m] <= '0;
        end else if (is_mrs && {cmd_bg, cmd_ba} == 3'(m)) begin
          mr_q[m] <= cmd_addr;
        end
      end
    end
  endgenerate

  logic [1:0] page;
  prs_pkg::prs_fmt_t fmt;
  logic bl_ok;
  logic bc4;

  assign mpr_on = mr_q[`PRS_MR_CTRL][`PRS_MR3_EN_BIT];
  assign page = mr_q[`PRS_MR_CTRL][`PRS_MR3_PAGE_LSB +: 2];
  assign fmt = prs_pkg::prs_fmt_t'(mr_q[`PRS_MR_CTRL][`PRS_MR3_FMT_LSB +: 2]);
  assign parity_en = mr_q[`PRS_MR_PARITY][2:0] != 3'h0;
  assign bc4 = mr_q[`PRS_MR_BURST][2:0] == `PRS_BC4_CODE;
  assign bl_ok = bc4 || mr_q[`PRS_MR_BURST][2:0] == `PRS_BL8_CODE;

  // ************************************
  // command steering
  // ************************************
  logic is_rd;
  logic is_wr;
  logic is_ap;

  assign is_rd = cmd_valid && (cmd_code == prs_pkg::PRS_CMD_RD ||
                               cmd_code == prs_pkg::PRS_CMD_RDA);
  assign is_wr = cmd_valid && (cmd_code == prs_pkg::PRS_CMD_WR ||
                               cmd_code == prs_pkg::PRS_CMD_WRA);
  assign is_ap = cmd_code == prs_pkg::PRS_CMD_RDA ||
                 cmd_code == prs_pkg::PRS_CMD_WRA;

  // array sees no read, write or precharge while the mode is on
  always_ff @(posedge dram_ck) begin
    if (lnk_rst) begin
      arr_cmd_valid <= 1'b0;
      arr_cmd_code <= prs_pkg::PRS_CMD_DES;
      arr_auto_pre <= 1'b0;
    end else begin
      arr_cmd_valid <= cmd_valid && !is_mrs && (!mpr_on ||
                       cmd_code == prs_pkg::PRS_CMD_REF);
      arr_cmd_code <= cmd_code;
      arr_auto_pre <= cmd_valid && is_ap && !mpr_on;
    end
  end

  // ************************************
  // page 0 storage
  // ************************************
  logic [31:0] p0_bytes;
  logic p0_wr;

  assign p0_wr = is_wr && mpr_on && page == 2'h0;

  prs_pattern_mem u_mem (
    .clk(dram_ck),
    .rst(lnk_rst),
    .init(reinit_evt),
    .wr_en(p0_wr),
    .wr_loc(cmd_ba),
    .wr_data(cmd_addr[7:0]),
    .rd_bytes(p0_bytes)
  );

  // ************************************
  // read source selection
  // ************************************
  function automatic logic [7:0] page_byte(input logic [1:0] pg,
                                           input logic [1:0] loc,
                                           input logic [31:0] p0,
                                           input logic [31:0] p1,
                                           input logic [7:0] p2);
    logic [7:0] b;
    b = 8'h00;
    unique case (pg)
      2'h0: b = p0[8*loc +: 8];
      2'h1: b = p1[8*loc +: 8];
      2'h2: b = p2;
      2'h3: b = 8'h00;
    endcase
    return b;
  endfunction

  prs_pkg::prs_fmt_t eff_fmt;
  logic [7:0] src_d [`PRS_LOCS];

  always_comb begin
    eff_fmt = prs_pkg::PRS_FMT_SERIAL;
    if (page == 2'h0 && fmt != prs_pkg::PRS_FMT_RSVD) begin
      eff_fmt = fmt;
    end
  end

  genvar k;
  generate
    for (k = 0; k < `PRS_LOCS; k++) begin : g_src
      logic [1:0] sloc;
      always_comb begin
        unique case (eff_fmt)
          prs_pkg::PRS_FMT_PARALLEL: sloc = 2'h0;
          prs_pkg::PRS_FMT_STAGGER: sloc = cmd_ba + 2'(k);
          default: sloc = cmd_ba;
        endcase
      end
      assign src_d[k] = page_byte(page, sloc, p0_bytes, err_page_q,
                                  mr_q[sloc][7:0]);
    end
  endgenerate

  // ************************************
  // burst engine
  // ************************************
  prs_pkg::prs_state_t state_q;
  prs_pkg::prs_fmt_t fmt_q;
  logic [7:0] src_q [`PRS_LOCS];
  logic [2:0] beat_q;
  logic [2:0] last_q;
  logic rd_start;

  assign rd_start = is_rd && mpr_on && bl_ok &&
                    state_q == prs_pkg::PRS_ST_IDLE;

  always_ff @(posedge dram_ck) begin
    if (lnk_rst) begin
      state_q <= prs_pkg::PRS_ST_IDLE;
      beat_q <= 3'h0;
    end else begin
      unique case (state_q)
        prs_pkg::PRS_ST_IDLE: begin
          beat_q <= 3'h0;
          if (rd_start) begin
            state_q <= prs_pkg::PRS_ST_BURST;
          end
        end
        prs_pkg::PRS_ST_BURST: begin
          beat_q <= beat_q + 3'h1;
          if (beat_q == last_q) begin
            state_q <= prs_pkg::PRS_ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge dram_ck) begin
    if (lnk_rst) begin
      fmt_q <= prs_pkg::PRS_FMT_SERIAL;
      last_q <= `PRS_BL8_LAST;
    end else if (rd_start) begin
      fmt_q <= eff_fmt;
      last_q <= bc4 ? `PRS_BC4_LAST : `PRS_BL8_LAST;
    end
  end

  generate
    for (k = 0; k < `PRS_LOCS; k++) begin : g_snap
      always_ff @(posedge dram_ck) begin
        if (lnk_rst) begin
          src_q[k] <= 8'h00;
        end else if (rd_start) begin
          src_q[k] <= src_d[k];
        end
      end
    end
  endgenerate

  // ************************************
  // lane drivers
  // ************************************
  logic [`PRS_LANES-1:0] lane_d;
  logic burst;

  assign burst = state_q == prs_pkg::PRS_ST_BURST;

  genvar j;
  generate
    for (j = 0; j < `PRS_LANES; j++) begin : g_lane
      always_comb begin
        if (fmt_q == prs_pkg::PRS_FMT_PARALLEL) begin
          lane_d[j] = src_q[0][3'(7 - (j % 8))];
        end else begin
          lane_d[j] = src_q[j % 4][3'h7 - beat_q];
        end
      end
    end
  endgenerate

  always_ff @(posedge dram_ck) begin
    if (lnk_rst) begin
      dq_o <= '0;
      dq_beat_valid <= 1'b0;
      dq_oe_n <= 1'b1;
    end else begin
      dq_o <= burst ? lane_d : '0;
      dq_beat_valid <= burst;
      dq_oe_n <= !burst;
    end
  end
endmodule

`default_nettype wire

// file: bench/prs_top_sva.sv
/* Port checker of the pattern block.
   Assumes it is bound to prs_top. */
`include "prs_defines.svh"
`default_nettype none
module prs_top_sva (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic err_frame_valid,
  input wire logic err_frame_busy,
  input wire logic dram_ck,
  input wire logic cmd_valid,
  input wire prs_pkg::prs_cmd_t cmd_code,
  input wire logic cmd_bg,
  input wire logic [1:0] cmd_ba,
  input wire logic [`PRS_MR_W-1:0] cmd_addr,
  input wire logic [`PRS_LANES-1:0] dq_o,
  input wire logic dq_oe_n,
  input wire logic dq_beat_valid,
  input wire logic arr_cmd_valid,
  input wire logic arr_auto_pre
);
  // ****
  // mode register shadow
  // ****
  logic mode_q;
  logic [1:0] page_q;
  logic [1:0] fmt_q;
  logic [2:0] bl_q;
  logic mrs;
  logic rd;
  logic rw;
  assign mrs = cmd_valid && cmd_code == prs_pkg::PRS_CMD_MRS;
  assign rd = cmd_valid && cmd_code inside {prs_pkg::PRS_CMD_RD, prs_pkg::PRS_CMD_RDA};
  assign rw = rd || cmd_valid && cmd_code inside {prs_pkg::PRS_CMD_WR, prs_pkg::PRS_CMD_WRA};
  always_ff @(posedge dram_ck) begin
    if (sys_rst) begin
      mode_q <= 1'b0;
      page_q <= 2'h0;
      fmt_q <= 2'h0;
    end else if (mrs && {cmd_bg, cmd_ba} == 3'h3) begin
      mode_q <= cmd_addr[2];
      page_q <= cmd_addr[1:0];
      fmt_q <= cmd_addr[12:11];
    end
  end
  always_ff @(posedge dram_ck) begin
    if (sys_rst) begin
      bl_q <= 3'h0;
    end else if (mrs && {cmd_bg, cmd_ba} == 3'h0) begin
      bl_q <= cmd_addr[2:0];
    end
  end
  // link-domain view of reset, stretched like the block's own
  logic [1:0] lrst_q;
  logic lk_rst;
  always_ff @(posedge dram_ck) begin
    lrst_q <= {lrst_q[0], sys_rst};
  end
  assign lk_rst = sys_rst || lrst_q[1];
  sequence s_bl8;
    dq_beat_valid [*8] ##1 !dq_beat_valid;
  endsequence
  sequence s_bc4;
    dq_beat_valid [*4] ##1 !dq_beat_valid;
  endsequence
  a_burst_eight:
    assert property (@(posedge dram_ck) disable iff (lk_rst)
      rd && mode_q && bl_q == 3'h0 |-> ##2 s_bl8) else $error("bl8 burst shape");
  a_burst_chop:
    assert property (@(posedge dram_ck) disable iff (lk_rst)
      rd && mode_q && bl_q == 3'h4 |-> ##2 s_bc4) else $error("bc4 burst shape");
  a_bad_code:
    assert property (@(posedge dram_ck) disable iff (lk_rst)
      rd && mode_q && !(bl_q inside {3'h0, 3'h4}) |=> (!dq_beat_valid) [*8])
      else $error("burst on bad code");
  a_rd_array:
    assert property (@(posedge dram_ck) disable iff (lk_rst)
      rd && !mode_q |=> arr_cmd_valid) else $error("read not forwarded");
  a_mode_steer:
    assert property (@(posedge dram_ck) disable iff (lk_rst)
      rw && mode_q |=> !arr_cmd_valid) else $error("access leaked to array");
  a_no_precharge:
    assert property (@(posedge dram_ck) disable iff (lk_rst)
      rw && mode_q |=> !arr_auto_pre) else $error("precharge in mode");
  a_oe_tracks:
    assert property (@(posedge dram_ck) disable iff (lk_rst)
      dq_beat_valid != dq_oe_n) else $error("enable and beat differ");
  a_serial_lanes:
    assert property (@(posedge dram_ck) disable iff (lk_rst)
      dq_beat_valid && (page_q != 2'h0 || !(fmt_q inside {2'h1, 2'h2}))
      |-> dq_o inside {8'h00, 8'hFF}) else $error("lanes differ in serial");
  a_parallel_hold:
    assert property (@(posedge dram_ck) disable iff (lk_rst)
      dq_beat_valid && $past(dq_beat_valid) && page_q == 2'h0 && fmt_q == 2'h1
      |-> $stable(dq_o)) else $error("parallel beat changed");
  a_frame_busy:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      err_frame_valid && !err_frame_busy |=> err_frame_busy) else $error("frame not taken");
endmodule
bind prs_top prs_top_sva chk_u (.core_clk(core_clk), .sys_rst(sys_rst),
  .err_frame_valid(err_frame_valid), .err_frame_busy(err_frame_busy), .dram_ck(dram_ck),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bg(cmd_bg), .cmd_ba(cmd_ba),
  .cmd_addr(cmd_addr), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dq_beat_valid(dq_beat_valid),
  .arr_cmd_valid(arr_cmd_valid), .arr_auto_pre(arr_auto_pre));
`default_nettype wire

// file: bench/prs_ctrl_model.sv
/* Memory controller model issuing commands on the link.
   Assumes a free running dram_ck. */
`include "prs_defines.svh"
`default_nettype none
module prs_ctrl_model (
  input wire logic dram_ck,
  output logic cmd_valid,
  output prs_pkg::prs_cmd_t cmd_code,
  output logic cmd_bg,
  output logic [1:0] cmd_ba,
  output logic [`PRS_MR_W-1:0] cmd_addr,
  input wire logic [`PRS_LANES-1:0] dq_o,
  input wire logic dq_beat_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // command issue
  // ****
  initial begin
    cmd_valid = 1'b0;
    cmd_code = prs_pkg::PRS_CMD_DES;
    {cmd_bg, cmd_ba, cmd_addr} = '0;
  end
  // never sends activate, power-down, self refresh or refresh
  // no inversion on reads; mode set only by mrs
  task automatic issue(input prs_pkg::prs_cmd_t c, input logic [2:0] i, input logic [12:0] a);
    @(posedge dram_ck);
    #1;
    cmd_valid = 1'b1;
    cmd_code = c;
    {cmd_bg, cmd_ba, cmd_addr} = {i, a};
    @(posedge dram_ck);
    #1;
    cmd_valid = 1'b0;
    cmd_code = prs_pkg::PRS_CMD_DES;
    {cmd_bg, cmd_ba, cmd_addr} = ~{i, a};
  endtask
  // whole burst collected before any other command
  task automatic rd(input logic [1:0] l, output logic [63:0] d, output int n);
    d = '0;
    n = 0;
    @(posedge dram_ck);
    issue(prs_pkg::PRS_CMD_RD, {1'b0, l}, 13'h0000);
    repeat (12) begin
      @(posedge dram_ck);
      #1;
      if (dq_beat_valid === 1'b1) begin
        d = {d[55:0], dq_o};
        n++;
      end
    end
  endtask
endmodule
`default_nettype wire

// file: bench/tb_prs_top.sv
/* Testbench of the pattern block.
   Assumes the controller model and the bound checker. */
`default_nettype none
module tb_prs_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic dram_ck = 1'b0;
  logic sys_rst = 1'b1;
  logic err_frame_valid = 1'b0;
  logic [31:0] err_frame = 32'h0;
  logic reinit = 1'b0;
  logic err_frame_busy, pattern_mode_active, dq_oe_n, dq_beat_valid, arr_cmd_valid;
  logic arr_auto_pre, cmd_valid, cmd_bg;
  logic [7:0] dq_o;
  logic [1:0] cmd_ba;
  logic [12:0] cmd_addr;
  prs_pkg::prs_cmd_t cmd_code, arr_cmd_code;
  logic [31:0] pat;
  logic [63:0] d;
  int n;
  int bad_count = 0;
  int samples_checked = 0;
  always #10 core_clk = ~core_clk;
  always #40 dram_ck = ~dram_ck;
  prs_ctrl_model ctl_u (.dram_ck(dram_ck), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_bg(cmd_bg), .cmd_ba(cmd_ba), .cmd_addr(cmd_addr), .dq_o(dq_o),
    .dq_beat_valid(dq_beat_valid));
  prs_top dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .err_frame_valid(err_frame_valid),
    .err_frame(err_frame), .err_frame_busy(err_frame_busy), .reinit(reinit),
    .pattern_mode_active(pattern_mode_active), .dram_ck(dram_ck), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_bg(cmd_bg), .cmd_ba(cmd_ba), .cmd_addr(cmd_addr),
    .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dq_beat_valid(dq_beat_valid),
    .arr_cmd_valid(arr_cmd_valid), .arr_cmd_code(arr_cmd_code), .arr_auto_pre(arr_auto_pre));
  // ****
  // expectation and checking
  // ****
  // burst of bytes w for format f, location l; beat 0 in the top byte
  function automatic logic [63:0] ex(input int f, input int l, input logic [31:0] w);
    logic [63:0] r;
    logic [7:0] v;
    for (int b = 0; b < 8; b++) begin
      for (int k = 0; k < 8; k++) begin
        v = f == 1 ? w[7:0] : w[8 * ((l + (f == 2 ? k : 0)) % 4) +: 8];
        r[56 - 8 * b + k] = f == 1 ? v[7 - k] : v[7 - b];
      end
    end
    return r;
  endfunction
  task automatic chk(input string s, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic rdc(input logic [1:0] l, input int f, input logic [31:0] w);
    ctl_u.rd(l, d, n);
    chk("burst", d, ex(f, l, w));
    chk("beats", n, 8);
  endtask
  task automatic mrs(input logic [2:0] i, input logic [12:0] a);
    ctl_u.issue(prs_pkg::PRS_CMD_MRS, i, a);
  endtask
  task automatic core_pulse(input logic f);
    @(posedge core_clk);
    #1;
    if (f) err_frame_valid = 1'b1;
    else reinit = 1'b1;
    @(posedge core_clk);
    #1;
    {err_frame_valid, reinit} = 2'b00;
    for (int i = 0; i < 40 && err_frame_busy !== 1'b0; i++) @(posedge core_clk);
    repeat (10) @(posedge dram_ck);
  endtask
  task automatic complete_run;
    $display("mismatches %0d of %0d checks", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  initial begin
    #300000;
    bad_count++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    repeat (5) @(posedge dram_ck);
    pat = 32'h000F3355;
    mrs(3'h3, 13'h0004);
    for (int l = 0; l < 4; l++) rdc(l, 0, pat);
    chk("mode", pattern_mode_active, 1);
    ctl_u.issue(prs_pkg::PRS_CMD_WR, 3'h2, 13'h00A5);
    ctl_u.issue(prs_pkg::PRS_CMD_WRA, 3'h3, 13'h003C);
    pat = 32'h3CA53355;
    rdc(2, 0, pat);
    rdc(3, 0, pat);
    mrs(3'h3, 13'h0804);
    rdc(0, 1, pat);
    mrs(3'h3, 13'h1004);
    for (int l = 0; l < 4; l++) rdc(l, 2, pat);
    mrs(3'h0, 13'h0004);
    mrs(3'h3, 13'h0004);
    ctl_u.rd(1, d, n);
    chk("chop", d, ex(0, 1, pat) >> 32);
    chk("chop beats", n, 4);
    mrs(3'h0, 13'h0001);
    ctl_u.rd(0, d, n);
    chk("bad code beats", n, 0);
    mrs(3'h0, 13'h0000);
    mrs(3'h3, 13'h1006);
    ctl_u.issue(prs_pkg::PRS_CMD_WR, 3'h3, 13'h0099);
    rdc(3, 0, 32'h06000000);
    mrs(3'h3, 13'h0007);
    rdc(1, 0, 32'h0);
    mrs(3'h5, 13'h0001);
    err_frame = 32'hC3A55A3C;
    core_pulse(1'b1);
    mrs(3'h3, 13'h0005);
    rdc(2, 0, err_frame);
    mrs(3'h3, 13'h0000);
    ctl_u.issue(prs_pkg::PRS_CMD_RDA, 3'h1, 13'h0000);
    chk("array", {arr_cmd_valid, arr_auto_pre, arr_cmd_code},
      {2'b11, prs_pkg::PRS_CMD_RDA});
    mrs(3'h3, 13'h0004);
    core_pulse(1'b0);
    chk("mode off", pattern_mode_active, 0);
    mrs(3'h3, 13'h0004);
    rdc(2, 0, 32'h000F3355);
    complete_run;
  end
endmodule
`default_nettype wire
